//--- rtl/lnkctl_map.svh
/*
 Timing counts and mode encodings for the single-wire bus transceiver control.
 Assumes a 100 MHz core clock.
*/
`ifndef LNKCTL_MAP_SVH
`define LNKCTL_MAP_SVH

// --------------------------------------------------
// Timing
// --------------------------------------------------
`define LNKCTL_CLK_MHZ 100
`define LNKCTL_TMO_MIN_MS 6
`define LNKCTL_TMO_TYP_MS 12
`define LNKCTL_TMO_MAX_MS 20
`define LNKCTL_TMO_CYCLES (`LNKCTL_TMO_TYP_MS * 1000 * `LNKCTL_CLK_MHZ)
`define LNKCTL_NORMAL_KBPS 20
`define LNKCTL_FLASH_KBPS 115
`define LNKCTL_MIN_BPS 1600

// --------------------------------------------------
// Mode encodings and reset values
// --------------------------------------------------
`define LNKCTL_MODE_NORMAL 2'h0
`define LNKCTL_MODE_RXONLY 2'h1
`define LNKCTL_MODE_FLASH 2'h2
`define LNKCTL_MODE_RST 2'h0
`define LNKCTL_TOE_RST 1'b1
`define LNKCTL_TXD_RST 1'b1
`define LNKCTL_OTF_RST 1'b0

`endif

//--- rtl/lnkctl_pkg.sv
/*
 Types for the single-wire bus transceiver control.
 Assumes lnkctl_map.svh holds the matching encodings.
*/
package lnkctl_pkg;
	typedef enum logic [1:0] {
		LNKCTL_NORMAL = 2'h0,
		LNKCTL_RXONLY = 2'h1,
		LNKCTL_FLASH = 2'h2
	} lnkctl_mode_t;
	typedef enum logic [1:0] {
		LNKCTL_IDLE = 2'h0,
		LNKCTL_TIMING = 2'h1,
		LNKCTL_BLOCKED = 2'h2
	} lnkctl_tmo_t;
endpackage

//--- rtl/lnkctl_sync.sv
/*
 Two-flop synchroniser for a level that arrives from outside the clock domain.
 Assumes a free-running clk and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module lnkctl_sync #(
	parameter logic RST_VAL = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Level
	input wire logic d,
	output logic q
);
	logic s1_r;
	logic s1_nxt;
	logic q_nxt;
	always_comb begin
		s1_nxt = clk_en ? d : s1_r;
		q_nxt = clk_en ? s1_r : q;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			s1_r <= s1_nxt;
			q <= q_nxt;
		end
	end
endmodule // lnkctl_sync

//--- rtl/lnkctl_top.sv
/*
 Digital control of a single-wire bus transceiver: mode select, dominant
 transmit timeout and overtemperature shutdown.
 Assumes the mode and timeout-enable bits come from configuration logic on clk,
 while the transmit input, bus level and thermal sensor come from pins.
*/
`timescale 1ns/1ps
`include "lnkctl_map.svh"
module lnkctl_top #(
	parameter int TMO_CYCLES = `LNKCTL_TMO_CYCLES
) (
	// Clock, enable and reset
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Configuration from the serial control port
	input wire logic [1:0] comm_mode,
	input wire logic tx_timeout_enable,
	input wire logic overtemp_flag_clr,
	// Microcontroller side
	input wire logic bus_tx_data_in,
	output logic bus_rx_data_out,
	// Bus pin, open drain
	input wire logic bus_line_pin_i,
	output logic bus_line_pin_o,
	output logic bus_line_pin_oe,
	// Analog driver control and diagnosis
	input wire logic overtemp_sense,
	output logic slope_ctrl_en,
	output logic current_limit_en,
	output logic bus_overtemp_flag,
	output logic wakeup_event
);
	// --------------------------------------------------
	// Parameter check and helpers
	// --------------------------------------------------
	// A count below two cannot tell one dominant bit from a stuck transmit input.
	if (TMO_CYCLES < 2) begin : g_tmo_check
		$error("TMO_CYCLES too small");
	end

	// Slope control and current limit share one decision, so they cannot drift apart.
	function automatic logic shaping_on(input lnkctl_pkg::lnkctl_mode_t m);
		return m != lnkctl_pkg::LNKCTL_FLASH;
	endfunction

	// --------------------------------------------------
	// Input synchronisers
	// --------------------------------------------------
	logic tx_s;
	logic rx_s;
	logic ot_s;
	lnkctl_sync #(.RST_VAL(1'b1)) u_tx (.clk(clk), .resetn(resetn), .clk_en(clk_en), .d(bus_tx_data_in), .q(tx_s));
	lnkctl_sync #(.RST_VAL(1'b1)) u_rx (.clk(clk), .resetn(resetn), .clk_en(clk_en), .d(bus_line_pin_i), .q(rx_s));
	lnkctl_sync #(.RST_VAL(1'b0)) u_ot (.clk(clk), .resetn(resetn), .clk_en(clk_en), .d(overtemp_sense), .q(ot_s));

	// --------------------------------------------------
	// Mode register
	// --------------------------------------------------
	lnkctl_pkg::lnkctl_mode_t mode_r;
	lnkctl_pkg::lnkctl_mode_t mode_nxt;
	logic toe_r;
	logic toe_nxt;
	// Code 3 is not a mode; it keeps the last mode, so a corrupted write cannot
	// select an undefined driver setting.
	always_comb begin
		mode_nxt = mode_r;
		toe_nxt = toe_r;
		if (clk_en) begin
			toe_nxt = tx_timeout_enable;
			case (comm_mode)
				`LNKCTL_MODE_NORMAL: mode_nxt = lnkctl_pkg::LNKCTL_NORMAL;
				`LNKCTL_MODE_RXONLY: mode_nxt = lnkctl_pkg::LNKCTL_RXONLY;
				`LNKCTL_MODE_FLASH: mode_nxt = lnkctl_pkg::LNKCTL_FLASH;
				default: mode_nxt = mode_r;
			endcase
		end
	end

	// --------------------------------------------------
	// Dominant timeout
	// --------------------------------------------------
	// The count starts at the synchronised falling edge, so the real timeout is a few
	// cycles longer than the count; that is far inside the allowed spread.
	// The overtemperature flag is sticky and a present overtemperature beats a clear,
	// so the driver cannot come back on while the stage is still hot.
	lnkctl_pkg::lnkctl_tmo_t st_r;
	lnkctl_pkg::lnkctl_tmo_t st_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic tx_d_r;
	logic tx_d_nxt;
	logic ot_flag_r;
	logic ot_flag_nxt;
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		tx_d_nxt = tx_d_r;
		ot_flag_nxt = ot_flag_r;
		if (clk_en) begin
			tx_d_nxt = tx_s;
			ot_flag_nxt = ot_s | (ot_flag_r & ~overtemp_flag_clr);
			case (st_r)
				lnkctl_pkg::LNKCTL_IDLE: begin
					cnt_nxt = 32'h0;
					if (toe_r && !tx_s && tx_d_r) begin
						st_nxt = lnkctl_pkg::LNKCTL_TIMING;
					end
				end
				lnkctl_pkg::LNKCTL_TIMING: begin
					if (!toe_r || tx_s) begin
						st_nxt = lnkctl_pkg::LNKCTL_IDLE;
						cnt_nxt = 32'h0;
					end else if (cnt_r >= 32'(TMO_CYCLES - 1)) begin
						st_nxt = lnkctl_pkg::LNKCTL_BLOCKED;
					end else begin
						cnt_nxt = cnt_r + 32'h1;
					end
				end
				lnkctl_pkg::LNKCTL_BLOCKED: begin
					cnt_nxt = 32'h0;
					if (tx_s && !tx_d_r) begin
						st_nxt = lnkctl_pkg::LNKCTL_IDLE;
					end else if (!toe_r) begin
						st_nxt = lnkctl_pkg::LNKCTL_IDLE;
					end
				end
				default: begin
					st_nxt = lnkctl_pkg::LNKCTL_IDLE;
					cnt_nxt = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_r <= lnkctl_pkg::lnkctl_mode_t'(`LNKCTL_MODE_RST);
			toe_r <= `LNKCTL_TOE_RST;
			st_r <= lnkctl_pkg::LNKCTL_IDLE;
			cnt_r <= 32'h0;
			tx_d_r <= `LNKCTL_TXD_RST;
			ot_flag_r <= `LNKCTL_OTF_RST;
		end else begin
			mode_r <= mode_nxt;
			toe_r <= toe_nxt;
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			tx_d_r <= tx_d_nxt;
			ot_flag_r <= ot_flag_nxt;
		end
	end

	// --------------------------------------------------
	// Outputs
	// --------------------------------------------------
	// The driver only ever pulls the line low, so a recessive transmit level can never
	// reach the bus as dominant, whatever the state of the rest of the logic.
	logic drive_dom;
	assign drive_dom = !tx_s && mode_r != lnkctl_pkg::LNKCTL_RXONLY
		&& st_r != lnkctl_pkg::LNKCTL_BLOCKED && !ot_flag_r;
	assign bus_line_pin_o = 1'b0;
	assign bus_line_pin_oe = drive_dom;
	assign bus_rx_data_out = rx_s;
	assign slope_ctrl_en = shaping_on(mode_r);
	assign current_limit_en = shaping_on(mode_r);
	assign bus_overtemp_flag = ot_flag_r;
	assign wakeup_event = 1'b0;

	// --------------------------------------------------
	// Assertions
	// --------------------------------------------------
	AST_TX_HIGH_NO_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
		tx_s |-> !bus_line_pin_oe) else $error("bus driven while tx high");
	AST_RXONLY_BLOCK: assert property (@(posedge clk) disable iff (!resetn)
		mode_r == lnkctl_pkg::LNKCTL_RXONLY |-> !bus_line_pin_oe) else $error("drive in rx-only");
	AST_RX_FOLLOWS: assert property (@(posedge clk) disable iff (!resetn)
		$past(clk_en) && $past(clk_en, 2) && $past(resetn) && $past(resetn, 2)
		|-> bus_rx_data_out == $past(bus_line_pin_i, 2)) else $error("rx not following bus");
	AST_OT_OFF: assert property (@(posedge clk) disable iff (!resetn)
		ot_flag_r |-> !bus_line_pin_oe) else $error("driver on in overtemp");
	AST_OT_SET: assert property (@(posedge clk) disable iff (!resetn)
		clk_en && ot_s |=> bus_overtemp_flag) else $error("overtemp flag not set");
	AST_BLOCK_HOLD: assert property (@(posedge clk) disable iff (!resetn)
		st_r == lnkctl_pkg::LNKCTL_BLOCKED |-> !bus_line_pin_oe) else $error("drive while blocked");
	AST_REENABLE: assert property (@(posedge clk) disable iff (!resetn)
		st_r == lnkctl_pkg::LNKCTL_BLOCKED && $past(st_r) == lnkctl_pkg::LNKCTL_BLOCKED
		&& st_nxt == lnkctl_pkg::LNKCTL_IDLE && toe_r |-> tx_s && !tx_d_r) else $error("re-enable without edge");
	AST_TOE_OFF: assert property (@(posedge clk) disable iff (!resetn)
		clk_en && !toe_r |=> st_r == lnkctl_pkg::LNKCTL_IDLE) else $error("timer runs while disabled");
	AST_FLASH_SLOPE: assert property (@(posedge clk) disable iff (!resetn)
		mode_r == lnkctl_pkg::LNKCTL_FLASH |-> !slope_ctrl_en && !current_limit_en) else $error("flash slope");
	AST_NO_WAKE: assert property (@(posedge clk) disable iff (!resetn)
		!wakeup_event) else $error("wake-up raised");
	COV_BLOCK: cover property (@(posedge clk) disable iff (!resetn) st_r == lnkctl_pkg::LNKCTL_BLOCKED);
	COV_RXONLY: cover property (@(posedge clk) disable iff (!resetn) mode_r == lnkctl_pkg::LNKCTL_RXONLY && !tx_s);
	COV_FLASH_TX: cover property (@(posedge clk) disable iff (!resetn)
		mode_r == lnkctl_pkg::LNKCTL_FLASH && bus_line_pin_oe);
	COV_OT: cover property (@(posedge clk) disable iff (!resetn) ot_flag_r);
	COV_REENABLE: cover property (@(posedge clk) disable iff (!resetn)
		st_r == lnkctl_pkg::LNKCTL_BLOCKED ##1 st_r == lnkctl_pkg::LNKCTL_IDLE);
	AST_TX_LOW_DRIVE: assert property (@(posedge clk) disable iff (!resetn)
		!tx_s && mode_r == lnkctl_pkg::LNKCTL_NORMAL && st_r != lnkctl_pkg::LNKCTL_BLOCKED && !ot_flag_r
		|-> bus_line_pin_oe) else $error("dominant not driven");
	AST_TMO_EXPIRE: assert property (@(posedge clk) disable iff (!resetn)
		clk_en && st_r == lnkctl_pkg::LNKCTL_TIMING && toe_r && !tx_s && cnt_r == 32'(TMO_CYCLES - 1)
		|=> st_r == lnkctl_pkg::LNKCTL_BLOCKED) else $error("timeout did not block");
	AST_TMO_RESTART: assert property (@(posedge clk) disable iff (!resetn)
		clk_en && st_r == lnkctl_pkg::LNKCTL_IDLE |=> cnt_r == 32'h0) else $error("timer not restarted");
endmodule // lnkctl_top

//--- testbench/lin_kline_transceiver_control_bench.sv
/*
 Self-checking bench for lnkctl_top with a far node model.
 Assumes a 100 MHz clock and a shortened timeout count.
*/
`timescale 1ns/1ps
module lin_kline_transceiver_control_bench;
	localparam int TMO = 50;
	logic clk, resetn, tx, pull, ot, clr, toe, t, p, en;
	logic [1:0] mode;
	wire logic pin_i, rx, pin_o, oe, slope, ilim, otf, wake;
	int fails, n_compared;
	lnkctl_top #(.TMO_CYCLES(TMO)) dut (.clk(clk), .resetn(resetn), .clk_en(en), .comm_mode(mode),
		.tx_timeout_enable(toe), .overtemp_flag_clr(clr), .bus_tx_data_in(tx), .bus_rx_data_out(rx),
		.bus_line_pin_i(pin_i), .bus_line_pin_o(pin_o), .bus_line_pin_oe(oe), .overtemp_sense(ot),
		.slope_ctrl_en(slope), .current_limit_en(ilim), .bus_overtemp_flag(otf), .wakeup_event(wake));
	lnkctl_bus_node node (.dut_oe(oe), .dut_o(pin_o), .node_pull(pull), .bus_level(pin_i));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Model: sink only when sending is allowed and the input is low.
	function automatic logic m_oe(input logic [1:0] m, input logic tv, input logic blk, input logic hot);
		return (m != 2'h1) && !tv && !blk && !hot;
	endfunction
	// Five cycles cover both synchronisers on the way out and back.
	task automatic set(input logic tv, input logic pv);
		@(posedge clk);
		tx <= tv;
		pull <= pv;
		cyc(5);
	endtask
	task automatic final_report();
		$display("Compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Clock, watchdog, sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#50000;
		fails++;
		final_report();
	end
	initial begin
		resetn = 1'b0;
		tx = 1'b1;
		pull = 1'b0;
		ot = 1'b0;
		clr = 1'b0;
		toe = 1'b1;
		en = 1'b1;
		mode = 2'h0;
		fails = 0;
		n_compared = 0;
		void'($urandom(32'h8AE7));
		cyc(12);
		chk(oe, 1'b0);
		chk(rx, 1'b1);
		chk(slope, 1'b1);
		chk(ilim, 1'b1);
		chk(pin_o, 1'b0);
		chk(otf, 1'b0);
		@(posedge clk);
		resetn <= 1'b1;
		for (int m = 0; m < 3; m++) begin
			@(posedge clk);
			mode <= 2'(m);
			for (int i = 0; i < 8; i++) begin
				t = 1'($urandom);
				p = 1'($urandom);
				set(t, p);
				chk(oe, m_oe(2'(m), t, 1'b0, 1'b0));
				chk(rx, !(m_oe(2'(m), t, 1'b0, 1'b0) || p));
				chk(slope, m != 2);
				chk(ilim, m != 2);
				chk(wake, 1'b0);
				set(1'b1, p);
			end
		end
		@(posedge clk);
		mode <= 2'h0;
		set(1'b0, 1'b0);
		cyc(TMO - 12);
		chk(oe, 1'b1);
		cyc(16);
		chk(oe, 1'b0);
		chk(rx, 1'b1);
		cyc(20);
		chk(oe, 1'b0);
		set(1'b1, 1'b0);
		set(1'b0, 1'b0);
		chk(oe, 1'b1);
		cyc(30);
		set(1'b1, 1'b0);
		set(1'b0, 1'b0);
		cyc(30);
		chk(oe, 1'b1);
		set(1'b1, 1'b0);
		@(posedge clk);
		toe <= 1'b0;
		set(1'b0, 1'b0);
		cyc(TMO + 20);
		chk(oe, 1'b1);
		set(1'b1, 1'b0);
		@(posedge clk);
		toe <= 1'b1;
		mode <= 2'h2;
		set(1'b0, 1'b0);
		chk(oe, 1'b1);
		@(posedge clk);
		ot <= 1'b1;
		cyc(5);
		chk(oe, 1'b0);
		chk(otf, 1'b1);
		chk(slope, 1'b0);
		set(1'b1, 1'b0);
		@(posedge clk);
		ot <= 1'b0;
		cyc(5);
		chk(otf, 1'b1);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		set(1'b0, 1'b0);
		chk(otf, 1'b0);
		chk(oe, 1'b1);
		set(1'b1, 1'b0);
		// Clock enable low freezes the synchronisers, so a new transmit level must not reach the bus.
		@(posedge clk);
		en <= 1'b0;
		set(1'b0, 1'b0);
		chk(oe, 1'b0);
		chk(rx, 1'b1);
		@(posedge clk);
		en <= 1'b1;
		cyc(5);
		chk(oe, 1'b1);
		chk(rx, 1'b0);
		set(1'b1, 1'b0);
		// Code 3 keeps the last mode, here flash.
		@(posedge clk);
		mode <= 2'h3;
		cyc(5);
		chk(slope, 1'b0);
		chk(ilim, 1'b0);
		// A second reset in mid-run must bring back the reset mode and normal sending.
		@(posedge clk);
		resetn <= 1'b0;
		cyc(3);
		chk(slope, 1'b1);
		chk(oe, 1'b0);
		chk(rx, 1'b1);
		@(posedge clk);
		resetn <= 1'b1;
		set(1'b0, 1'b0);
		chk(slope, 1'b1);
		chk(oe, 1'b1);
		chk(rx, 1'b0);
		set(1'b1, 1'b0);
		final_report();
	end
endmodule // lin_kline_transceiver_control_bench

//--- testbench/lnkctl_bus_node.sv
/*
 Far bus node and pull-up on the single-wire line.
 Assumes the device pin is open drain.
*/
`timescale 1ns/1ps
module lnkctl_bus_node (
	// Pin and far node
	input wire logic dut_oe,
	input wire logic dut_o,
	input wire logic node_pull,
	output logic bus_level
);
	// The pull-up wins unless some party sinks the line.
	assign bus_level = !((dut_oe && !dut_o) || node_pull);
endmodule // lnkctl_bus_node
